// *** multi_channel_pwm_timer.sv ***
// 16-bit timer with four channels, dead time, encoder and slave modes
// Functional notes
// (RULE1) 16-bit auto-reload counter counting up, down or up-then-down.
// (RULE2) prescaler divides the clock by any ratio 1 to 65536.
// (RULE3) four channels: capture, compare, pwm or one-pulse output.
// (RULE4) pwm works edge-aligned and centre-aligned.
// (RULE5) advanced variant drives complementary pairs with programmable dead time.
// (RULE6) advanced variant serves as three-phase pwm on six outputs.
// (RULE7) advanced pwm covers duty from always off to always on.
// (RULE8) debug halt can freeze counter; advanced variant can blank outputs.
// (RULE9) each timer raises its own dma request.
// (RULE10) trigger in/out lets timers reset, start or clock each other.
// (RULE11) general timer decodes quadrature encoder, counting up or down.
// (RULE12) general timer takes one to three hall sensor inputs.
// (RULE13) basic variant counts up only, no channels, triggers dac. Here basic masks its channels, and encoder mode counts down.
// (RULE14) overflow or underflow reloads and raises update event.
// (RULE15) new prescale ratio applies only from the next update. Here it is also taken while the counter is idle.
//
// The implementer's own choices: the address map and the strobed register port.
`timescale 1ns/1ps
`include "pwm_timer_defines.svh"
module multi_channel_pwm_timer #(
  parameter int VARIANT = 0,
  parameter int W       = 16,
  parameter int NCH     = 4,
  parameter int DW      = 8
) (
  input  wire logic            core_clk,
  input  wire logic            reset_n,
  input  wire logic [7:0]      reg_addr,
  input  wire logic [31:0]     reg_wdata,
  input  wire logic            reg_wr,
  input  wire logic            reg_rd,
  output logic      [31:0]     reg_rdata,
  input  wire logic [NCH-1:0]  ch_in,
  output logic      [NCH-1:0]  ch_out,
  output logic      [NCH-1:0]  ch_oe,
  output logic      [NCH-1:0]  ch_out_n,
  output logic      [NCH-1:0]  ch_oe_n,
  input  wire logic            dbg_halt,
  input  wire logic            trig_in,
  output logic                 trig_out,
  output logic                 dac_trig,
  output logic                 dma_req,
  output logic                 irq
);
  localparam logic BASIC = (VARIANT == 2);
  localparam logic ADV   = (VARIANT == 0);

  pwm_timer_pkg::ctrl_s      ctrl;
  pwm_timer_pkg::cnt_state_e state;
  pwm_timer_pkg::chan_cfg_s  chcfg [NCH];
  logic [W-1:0]        compare [NCH];
  logic [W-1:0]        captured [NCH];
  logic [W-1:0]        count;
  logic [W-1:0]        reload;
  logic [W-1:0]        prescale;
  logic [W-1:0]        prescale_act;
  logic [W-1:0]        psc_cnt;
  logic [DW-1:0]       dead;
  logic [`STAT_W-1:0]  status;
  logic [`STAT_W-1:0]  irq_en;
  logic [`STAT_W-1:0]  dma_en;
  logic [`STAT_W-1:0]  events;
  logic [NCH-1:0]      ch_evt;
  logic [NCH-1:0]      pos_out;
  logic [NCH-1:0]      neg_out;
  logic [NCH-1:0]      out_en;
  logic [NCH-1:0]      neg_en;
  logic                main_en;
  logic [NCH-1:0]      sync1;
  logic [NCH-1:0]      sync2;
  logic [NCH-1:0]      sync3;
  logic                hall_q;
  logic                hall_lvl;
  logic [NCH-1:0]      cap_rise;
  logic                frozen;
  logic                run;
  logic                psc_tick;
  logic                tick;
  logic                enc_step;
  logic                enc_up;
  logic                upd;
  logic                any_onepulse;
  logic                wr_ctrl;

  // ---------------------------------
  // pin synchronisers
  // ---------------------------------
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      sync1  <= '0;
      sync2  <= '0;
      sync3  <= '0;
      hall_q <= 1'b0;
    end
    else
    begin
      sync1  <= ch_in;
      sync2  <= sync1;
      sync3  <= sync2;
      hall_q <= hall_lvl;
    end
  end

  // (RULE12) any hall edge captures on channel 0
  assign hall_lvl = ^sync2[2:0];

  always_comb
  begin
    cap_rise = sync2 & ~sync3;
    if (ctrl.hall)
      cap_rise[0] = hall_lvl ^ hall_q;
  end

  // (RULE11) x4 quadrature decode on inputs 0 and 1
  assign enc_step = (sync2[0] ^ sync3[0]) | (sync2[1] ^ sync3[1]);
  assign enc_up   = sync2[0] ^ sync3[1];

  // ---------------------------------
  // count enable and tick
  // ---------------------------------
  // (RULE8) debug halt freezes the counter
  assign frozen = ctrl.freeze & dbg_halt;
  assign run    = ctrl.en & !frozen &
                  !(ctrl.slave == pwm_timer_pkg::SL_GATED && !trig_in);
  assign psc_tick = run && psc_cnt == prescale_act;

  // (RULE10) another timer's trigger clocks this counter
  always_comb
  begin
    case (ctrl.slave)
      pwm_timer_pkg::SL_EXTCLK:  tick = run & trig_in;
      pwm_timer_pkg::SL_ENCODER: tick = run & enc_step;
      default:                   tick = psc_tick;
    endcase
  end

  // (RULE2) divide by prescale plus one
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
      psc_cnt <= '0;
    else if (upd || !run)
      psc_cnt <= '0;
    else if (psc_tick)
      psc_cnt <= '0;
    else
      psc_cnt <= psc_cnt + 1'b1;
  end

  // (RULE15) ratio latched at update, or while the counter is idle
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
      prescale_act <= `RST_PRESCALE;
    else if (upd || state == pwm_timer_pkg::CNT_IDLE)
      prescale_act <= prescale;
  end

  // ---------------------------------
  // counter
  // ---------------------------------
  always_comb
  begin
    upd = 1'b0;
    if (ctrl.slave == pwm_timer_pkg::SL_RESET && trig_in && ctrl.en)
      upd = 1'b1;
    else if (tick && ctrl.slave == pwm_timer_pkg::SL_ENCODER)
      upd = enc_up ? count >= reload : count == '0;
    else if (tick && state == pwm_timer_pkg::CNT_UP)
      upd = count >= reload;
    else if (tick && state == pwm_timer_pkg::CNT_DOWN)
      upd = count == '0;
  end

  // (RULE1) up, down and centre counting with reload
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      count <= '0;
      state <= pwm_timer_pkg::CNT_IDLE;
    end
    else if (ctrl.slave == pwm_timer_pkg::SL_RESET && trig_in && ctrl.en)
      count <= (state == pwm_timer_pkg::CNT_DOWN) ? reload : '0;
    else if (ctrl.slave == pwm_timer_pkg::SL_ENCODER)
    begin
      state <= pwm_timer_pkg::CNT_UP;
      if (tick)
      begin
        if (enc_up)
          count <= (count >= reload) ? '0 : count + 1'b1;
        else
          count <= (count == '0) ? reload : count - 1'b1;
      end
    end
    else
    begin
      case (state)
        pwm_timer_pkg::CNT_IDLE:
          if (ctrl.en)
            // (RULE13) basic variant never starts counting down; only encoder mode counts it down
            state <= (ctrl.down && !ctrl.center && !BASIC)
                     ? pwm_timer_pkg::CNT_DOWN : pwm_timer_pkg::CNT_UP;
        pwm_timer_pkg::CNT_UP:
          if (tick)
          begin
            // (RULE14) overflow reloads from zero
            if (count >= reload)
            begin
              if (ctrl.center && !BASIC)
              begin
                state <= pwm_timer_pkg::CNT_DOWN;
                count <= count - 1'b1;
              end
              else
                count <= '0;
            end
            else
              count <= count + 1'b1;
          end
        pwm_timer_pkg::CNT_DOWN:
          if (tick)
          begin
            // (RULE14) underflow reloads from reload
            if (count == '0)
            begin
              if (ctrl.center)
              begin
                state <= pwm_timer_pkg::CNT_UP;
                count <= count + 1'b1;
              end
              else
                count <= reload;
            end
            else
              count <= count - 1'b1;
          end
        default:
          state <= pwm_timer_pkg::CNT_IDLE;
      endcase
      if (wr_ctrl && !reg_wdata[`CTRL_EN])
        state <= pwm_timer_pkg::CNT_IDLE;
      else if (wr_ctrl && state == pwm_timer_pkg::CNT_IDLE)
        state <= pwm_timer_pkg::CNT_IDLE;
    end
  end

  // ---------------------------------
  // channels
  // ---------------------------------
  always_comb
  begin
    any_onepulse = 1'b0;
    for (int i = 0; i < NCH; i++)
      any_onepulse |= chcfg[i].mode == pwm_timer_pkg::CH_ONEPULSE;
  end

  // (RULE3) four independent channels, kept for basic but with outputs and events masked
  // (RULE6) three pairs plus a fourth make the phase outputs
  for (genvar i = 0; i < NCH; i++)
  begin : g_ch
    pwm_channel #(
      .W  (W),
      .DW (DW)
    ) u_ch (
      .core_clk    (core_clk),
      .reset_n     (reset_n),
      .tick        (tick),
      .count       (count),
      .cfg         (chcfg[i]),
      .compare     (compare[i]),
      .cap_rise    (cap_rise[i]),
      .dead        (ADV ? dead : '0),
      .event_pulse (ch_evt[i]),
      .captured    (captured[i]),
      .pos_out     (pos_out[i]),
      .neg_out     (neg_out[i])
    );
  end

  // (RULE8) blank outputs during debug halt
  always_comb
  begin
    for (int i = 0; i < NCH; i++)
    begin
      ch_oe[i]   = !BASIC && main_en && out_en[i] &&
                   chcfg[i].mode != pwm_timer_pkg::CH_CAPTURE &&
                   !(ADV && ctrl.dbg_off && dbg_halt);
      // (RULE5) complementary side exists on the advanced variant only
      ch_oe_n[i] = ADV && ch_oe[i] && neg_en[i];
    end
  end

  assign ch_out   = pos_out;
  assign ch_out_n = neg_out;

  // ---------------------------------
  // events, interrupt, dma, triggers
  // ---------------------------------
  assign events = {BASIC ? {NCH{1'b0}} : ch_evt, upd};

  // set wins over a simultaneous clear
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
      status <= '0;
    else
    begin
      if (reg_wr && reg_addr == `OFF_CLEAR)
        status <= (status & ~reg_wdata[`STAT_W-1:0]) | events;
      else
        status <= status | events;
    end
  end

  assign irq = |(status & irq_en);

  // (RULE9) dma request per timer on enabled events
  // (RULE10) update pulse drives the link to other timers
  // (RULE13) update also triggers the dac
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      dma_req  <= 1'b0;
      trig_out <= 1'b0;
      dac_trig <= 1'b0;
    end
    else
    begin
      dma_req  <= |(events & dma_en);
      trig_out <= upd;
      dac_trig <= upd;
    end
  end

  // ---------------------------------
  // register writes
  // ---------------------------------
  assign wr_ctrl = reg_wr && reg_addr == `OFF_CTRL;

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
      ctrl <= pwm_timer_pkg::ctrl_s'(`RST_CTRL);
    else if (wr_ctrl)
      ctrl <= pwm_timer_pkg::ctrl_s'(reg_wdata[`CTRL_W-1:0]);
    // (RULE10) trigger starts the counter
    else if (ctrl.slave == pwm_timer_pkg::SL_START && trig_in)
      ctrl.en <= 1'b1;
    // one-pulse stops at the update
    else if (upd && (ctrl.onepulse || any_onepulse))
      ctrl.en <= 1'b0;
  end

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      prescale <= `RST_PRESCALE;
      reload   <= `RST_RELOAD;
      dead     <= `RST_DEADTIME;
      irq_en   <= '0;
      dma_en   <= '0;
      main_en  <= 1'b0;
      out_en   <= '0;
      neg_en   <= '0;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        `OFF_PRESCALE: prescale <= reg_wdata[W-1:0];
        `OFF_RELOAD:   reload   <= reg_wdata[W-1:0];
        `OFF_DEADTIME: dead     <= reg_wdata[DW-1:0];
        `OFF_IRQ_EN:   irq_en   <= reg_wdata[`STAT_W-1:0];
        `OFF_DMA_EN:   dma_en   <= reg_wdata[`STAT_W-1:0];
        `OFF_OUTEN:
        begin
          out_en  <= reg_wdata[NCH-1:0];
          neg_en  <= reg_wdata[2*NCH-1:NCH];
          main_en <= reg_wdata[2*NCH];
        end
        default: ;
      endcase
    end
  end

  // per-channel config and compare, word per channel
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      for (int i = 0; i < NCH; i++)
      begin
        chcfg[i]   <= '0;
        compare[i] <= '0;
      end
    end
    else if (reg_wr)
    begin
      for (int i = 0; i < NCH; i++)
      begin
        if (reg_addr == `OFF_CHCFG0 + 8'(4 * i))
          chcfg[i] <= pwm_timer_pkg::chan_cfg_s'(reg_wdata[2:0]);
        if (reg_addr == `OFF_COMPARE0 + 8'(4 * i))
          compare[i] <= reg_wdata[W-1:0];
      end
    end
  end

  // ---------------------------------
  // register reads
  // ---------------------------------
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
      reg_rdata <= '0;
    else if (reg_rd)
    begin
      reg_rdata <= '0;
      case (reg_addr)
        `OFF_CTRL:     reg_rdata <= 32'(ctrl);
        `OFF_PRESCALE: reg_rdata <= 32'(prescale);
        `OFF_RELOAD:   reg_rdata <= 32'(reload);
        `OFF_COUNT:    reg_rdata <= 32'(count);
        `OFF_STATUS:   reg_rdata <= 32'(status);
        `OFF_IRQ_EN:   reg_rdata <= 32'(irq_en);
        `OFF_DMA_EN:   reg_rdata <= 32'(dma_en);
        `OFF_DEADTIME: reg_rdata <= 32'(dead);
        `OFF_OUTEN:    reg_rdata <= 32'({main_en, neg_en, out_en});
        default:
          for (int i = 0; i < NCH; i++)
          begin
            if (reg_addr == `OFF_CHCFG0 + 8'(4 * i))
              reg_rdata <= 32'(chcfg[i]);
            // capture channels read back the captured count
            if (reg_addr == `OFF_COMPARE0 + 8'(4 * i))
              reg_rdata <= 32'((chcfg[i].mode == pwm_timer_pkg::CH_CAPTURE)
                               ? captured[i] : compare[i]);
          end
      endcase
    end
  end
endmodule

// *** multi_channel_pwm_timer_tb.sv ***
// self-checking bench of the pwm timer
`timescale 1ns/1ps
module multi_channel_pwm_timer_tb;
  logic        core_clk  = 1'b0;
  logic        reset_n   = 1'b0;
  logic [7:0]  reg_addr  = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr    = 1'b0;
  logic        reg_rd    = 1'b0;
  logic        dbg_halt  = 1'b0;
  logic        trig_in   = 1'b0;
  logic        step      = 1'b0;
  logic        dir       = 1'b0;
  logic        cap       = 1'b0;
  logic [31:0] reg_rdata;
  logic [3:0]  ch_in;
  logic [3:0]  ch_out;
  logic [3:0]  ch_oe;
  logic [3:0]  ch_out_n;
  logic [3:0]  ch_oe_n;
  logic        trig_out;
  logic        dac_trig;
  logic        dma_req;
  logic        irq;
  int          n_errors        = 0;
  int          samples_checked = 0;
  int          cycles          = 0;
  multi_channel_pwm_timer #(
    .VARIANT(0)
  ) u_multi_channel_pwm_timer (
    .core_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .ch_in, .ch_out, .ch_oe, .ch_out_n, .ch_oe_n,
    .dbg_halt, .trig_in, .trig_out, .dac_trig, .dma_req, .irq
  );
  pwm_timer_partner u_pwm_timer_partner (
    .core_clk, .step, .dir, .cap, .ch_in
  );
  // --------
  // bus and check helpers
  // --------
  always #20 core_clk = ~core_clk;
  // hang guard, far above the few hundred cycles needed
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_errors++;
      test_done();
    end
  end
  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] s);
    samples_checked++;
    if (s !== e)
    begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  // data appear in the cycle after the strobe and hold until the next read
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task automatic next_trig(output int c);
    c = 0;
    do
    begin
      @(posedge core_clk);
      #1 c++;
    end
    while (trig_out !== 1'b1 && c < 300);
  endtask
  task automatic walk(input logic d);
    repeat (4)
    begin
      @(posedge core_clk);
      step <= 1'b1;
      dir  <= d;
      @(posedge core_clk);
      step <= 1'b0;
      repeat (4) @(posedge core_clk);
    end
  endtask
  // --------
  // scenarios
  // --------
  task automatic t_reset();
    logic [31:0] v;
    logic [7:0]  ad [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h48};
    logic [31:0] ex [6] = '{32'h0, 32'h0, 32'hFFFF, 32'h0, 32'h0, 32'h0};
    wr(8'h48, 32'hFFFF);
    for (int i = 0; i < 6; i++)
    begin
      rd(ad[i], v);
      chk("reset value", ex[i], v);
    end
    wr(8'h04, 32'hFFFF);
    rd(8'h04, v);
    chk("prescale max", 32'hFFFF, v);
    wr(8'h04, 32'h0);
    $display("end reset test");
  endtask
  task automatic t_modes();
    int          c;
    logic [31:0] md [3] = '{32'h1, 32'h3, 32'h5};
    logic [31:0] ex [3] = '{32'h4, 32'h4, 32'h3};
    wr(8'h08, 32'h3);
    for (int i = 0; i < 3; i++)
    begin
      wr(8'h00, 32'h0);
      wr(8'h00, md[i]);
      next_trig(c);
      next_trig(c);
      chk("period", ex[i], 32'(c));
    end
    wr(8'h00, 32'h1);
    next_trig(c);
    wr(8'h04, 32'h1);
    next_trig(c);
    // two of the four edges went by inside the write
    chk("old ratio", 32'h2, 32'(c));
    next_trig(c);
    chk("new ratio", 32'h8, 32'(c));
    wr(8'h00, 32'h0);
    wr(8'h04, 32'h0);
    $display("end count test");
  endtask
  task automatic t_irq();
    int          c;
    logic [31:0] v;
    wr(8'h14, 32'h1F);
    wr(8'h18, 32'h1);
    wr(8'h1C, 32'h1);
    wr(8'h00, 32'h1);
    next_trig(c);
    chk("dma pulse", 32'h1, 32'(dma_req));
    wr(8'h00, 32'h0);
    rd(8'h10, v);
    chk("status", 32'h1, v);
    chk("irq set", 32'h1, 32'(irq));
    wr(8'h18, 32'h0);
    #1 chk("irq masked", 32'h0, 32'(irq));
    wr(8'h18, 32'h1);
    #1 chk("irq unmasked", 32'h1, 32'(irq));
    wr(8'h14, 32'h1);
    #1 chk("irq cleared", 32'h0, 32'(irq));
    $display("end irq test");
  endtask
  task automatic t_pwm();
    logic [31:0] v;
    logic [31:0] w;
    logic        hi;
    logic        lo;
    logic [31:0] ctl [4] = '{32'h1, 32'h5, 32'h1, 32'h1};
    logic [31:0] cmp [4] = '{32'h2, 32'h2, 32'h0, 32'h4};
    logic [1:0]  ex  [4] = '{2'h3, 2'h3, 2'h1, 2'h2};
    wr(8'h20, 32'h2);
    wr(8'h40, 32'h1);
    wr(8'h44, 32'h111);
    for (int i = 0; i < 4; i++)
    begin
      wr(8'h00, 32'h0);
      wr(8'h30, cmp[i]);
      wr(8'h00, ctl[i]);
      repeat (10) @(posedge core_clk);
      hi = 1'b0;
      lo = 1'b0;
      repeat (16)
      begin
        @(posedge core_clk);
        #1 hi |= ch_out[0];
        lo |= ~ch_out[0];
      end
      chk("pwm levels", 32'(ex[i]), 32'({hi, lo}));
      chk("drive on", 32'h1, 32'(ch_oe[0] & ch_oe_n[0]));
      if (i > 1)
        chk("pair", 32'(!ch_out[0]), 32'(ch_out_n[0]));
    end
    wr(8'h00, 32'h181);
    dbg_halt <= 1'b1;
    rd(8'h0C, v);
    rd(8'h0C, w);
    chk("frozen", v, w);
    chk("blanked", 32'h0, 32'({ch_oe, ch_oe_n}));
    @(posedge core_clk);
    dbg_halt <= 1'b0;
    wr(8'h00, 32'h0);
    $display("end pwm test");
  endtask
  task automatic t_trig();
    int          c;
    logic [31:0] v;
    wr(8'h00, 32'h38);
    @(posedge core_clk);
    trig_in <= 1'b1;
    @(posedge core_clk);
    trig_in <= 1'b0;
    next_trig(c);
    chk("started", 32'h1, 32'(c < 10));
    rd(8'h00, v);
    chk("one pulse", 32'h38, v);
    wr(8'h00, 32'h0);
    $display("end trigger test");
  endtask
  task automatic t_enc();
    logic [31:0] a;
    logic [31:0] b;
    wr(8'h20, 32'h0);
    wr(8'h08, 32'hFFFF);
    wr(8'h14, 32'h1F);
    wr(8'h00, 32'h251);
    rd(8'h0C, a);
    walk(1'b1);
    rd(8'h0C, b);
    chk("enc up", a + 32'h4, b);
    walk(1'b0);
    rd(8'h0C, b);
    chk("enc down", a, b);
    rd(8'h10, b);
    chk("hall event", 32'h1, 32'(b[1]));
    @(posedge core_clk);
    cap <= 1'b1;
    repeat (4) @(posedge core_clk);
    cap <= 1'b0;
    repeat (4) @(posedge core_clk);
    rd(8'h10, b);
    chk("capture flag", 32'h1, 32'(b[4]));
    rd(8'h3C, b);
    chk("captured", a, b);
    $display("end encoder test");
  endtask
  initial
  begin
    repeat (5) @(posedge core_clk);
    reset_n <= 1'b1;
    t_reset();
    t_modes();
    t_irq();
    t_pwm();
    t_trig();
    t_enc();
    test_done();
  end
endmodule

// *** pwm_channel.sv ***
// one capture/compare channel with dead-time pair output
`timescale 1ns/1ps
module pwm_channel #(
  parameter int W  = 16,
  parameter int DW = 8
) (
  input  wire logic                     core_clk,
  input  wire logic                     reset_n,
  input  wire logic                     tick,
  input  wire logic [W-1:0]             count,
  input  wire pwm_timer_pkg::chan_cfg_s cfg,
  input  wire logic [W-1:0]             compare,
  input  wire logic                     cap_rise,
  input  wire logic [DW-1:0]            dead,
  output logic                          event_pulse,
  output logic [W-1:0]                  captured,
  output logic                          pos_out,
  output logic                          neg_out
);
  logic          ref_lvl;
  logic          ref_q;
  logic          toggle;
  logic [DW-1:0] dead_cnt;

  // ---------------------------------
  // reference waveform
  // ---------------------------------
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
      toggle <= 1'b0;
    else if (cfg.mode == pwm_timer_pkg::CH_COMPARE && tick && count == compare)
      toggle <= ~toggle;
  end

  always_comb
  begin
    case (cfg.mode)
      // (RULE4) level compare serves both alignments
      // (RULE7) zero compare never active, above reload always active
      pwm_timer_pkg::CH_PWM:      ref_lvl = count < compare;
      pwm_timer_pkg::CH_ONEPULSE: ref_lvl = count < compare;
      pwm_timer_pkg::CH_COMPARE:  ref_lvl = toggle;
      default:                    ref_lvl = 1'b0;
    endcase
  end

  // ---------------------------------
  // capture and events
  // ---------------------------------
  // (RULE3) capture or compare event
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      captured    <= '0;
      event_pulse <= 1'b0;
    end
    else if (cfg.mode == pwm_timer_pkg::CH_CAPTURE)
    begin
      event_pulse <= cap_rise;
      if (cap_rise)
        captured <= count;
    end
    else
      event_pulse <= tick && count == compare;
  end

  // ---------------------------------
  // dead time
  // ---------------------------------
  // (RULE5) both sides inactive for dead cycles on each edge
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      ref_q    <= 1'b0;
      dead_cnt <= '0;
    end
    else
    begin
      ref_q <= ref_lvl;
      if (ref_lvl != ref_q)
        dead_cnt <= dead;
      else if (dead_cnt != '0)
        dead_cnt <= dead_cnt - 1'b1;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      pos_out <= 1'b0;
      neg_out <= 1'b0;
    end
    else
    begin
      pos_out <= (ref_q && dead_cnt == '0) ^ cfg.active_low;
      neg_out <= (!ref_q && dead_cnt == '0) ^ cfg.active_low;
    end
  end
endmodule

// *** pwm_timer_defines.svh ***
// offsets, field positions, reset values of the pwm timer
`ifndef PWM_TIMER_DEFINES_SVH
`define PWM_TIMER_DEFINES_SVH
`define OFF_CTRL      8'h00
`define OFF_PRESCALE  8'h04
`define OFF_RELOAD    8'h08
`define OFF_COUNT     8'h0C
`define OFF_STATUS    8'h10
`define OFF_CLEAR     8'h14
`define OFF_IRQ_EN    8'h18
`define OFF_DMA_EN    8'h1C
`define OFF_CHCFG0    8'h20
`define OFF_COMPARE0  8'h30
`define OFF_DEADTIME  8'h40
`define OFF_OUTEN     8'h44
`define CTRL_EN       0
`define CTRL_DOWN     1
`define CTRL_CENTER   2
`define CTRL_ONEPULSE 3
`define CTRL_SLAVE_LO 4
`define CTRL_FREEZE   7
`define CTRL_DBG_OFF  8
`define CTRL_HALL     9
`define CTRL_W        10
`define STAT_UPDATE   0
`define STAT_CH_LO    1
`define STAT_W        5
`define RST_CTRL      10'h000
`define RST_RELOAD    16'hFFFF
`define RST_PRESCALE  16'h0000
`define RST_DEADTIME  8'h00
`endif

// *** pwm_timer_monitor.sv ***
// checker of the pwm timer ports
`timescale 1ns/1ps
module pwm_timer_monitor #(
  parameter int NCH = 4
) (
  input wire logic           core_clk,
  input wire logic           reset_n,
  input wire logic [7:0]     reg_addr,
  input wire logic [31:0]    reg_wdata,
  input wire logic           reg_wr,
  input wire logic [NCH-1:0] ch_out,
  input wire logic [NCH-1:0] ch_oe,
  input wire logic [NCH-1:0] ch_out_n,
  input wire logic [NCH-1:0] ch_oe_n,
  input wire logic           dbg_halt,
  input wire logic           trig_out,
  input wire logic           dac_trig,
  input wire logic           dma_req,
  input wire logic           irq
);
  logic [15:0] reload_cfg;
  logic [8:0]  outen_cfg;
  logic [4:0]  irq_cfg;
  logic [4:0]  dma_cfg;
  logic [7:0]  dead_cfg;
  logic        blank_cfg;
  // --------
  // register shadows
  // --------
  // land on the same edge as the real registers, so no lag
  always_ff @(posedge core_clk)
    if (!reset_n)
    begin
      reload_cfg <= 16'hFFFF;
      outen_cfg  <= 9'h000;
      irq_cfg    <= 5'h00;
      dma_cfg    <= 5'h00;
      dead_cfg   <= 8'h00;
      blank_cfg  <= 1'b0;
    end
    else if (reg_wr)
      case (reg_addr)
        8'h00: blank_cfg <= reg_wdata[8];
        8'h08: reload_cfg <= reg_wdata[15:0];
        8'h18: irq_cfg <= reg_wdata[4:0];
        8'h1C: dma_cfg <= reg_wdata[4:0];
        8'h40: dead_cfg <= reg_wdata[7:0];
        8'h44: outen_cfg <= reg_wdata[8:0];
        default: ;
      endcase
  default clocking mon_cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);
  sequence s_main_on;
    dead_cfg != 8'h00 ##0 $rose(ch_out[0]);
  endsequence
  // reload of 0 or 1 may legally update on every tick
  sequence s_update;
    trig_out && reload_cfg > 16'h0001;
  endsequence
  // --------
  // assertions
  // --------
  AST_DAC_FOLLOWS: assert property (trig_out == dac_trig)
    else $error("dac trigger differs from update pulse");
  AST_UPD_SINGLE: assert property (s_update |=> !trig_out)
    else $error("update pulse longer than one cycle");
  AST_NO_OVERLAP: assert property
    ((ch_out & ch_out_n & ch_oe & ch_oe_n) == '0)
    else $error("both outputs of a pair active");
  AST_DEAD_GAP: assert property
    (s_main_on |-> $past(ch_out_n[0]) == 1'b0)
    else $error("main output rose without dead time");
  AST_DBG_BLANK: assert property
    (dbg_halt && blank_cfg |-> ch_oe == '0 && ch_oe_n == '0)
    else $error("outputs driven during debug halt");
  AST_OE_MASTER: assert property
    (!outen_cfg[8] |-> ch_oe == '0 && ch_oe_n == '0)
    else $error("outputs driven without master enable");
  AST_IRQ_MASK: assert property (irq_cfg == 5'h00 |-> !irq)
    else $error("interrupt with all sources masked");
  AST_DMA_MASK: assert property
    (dma_cfg == 5'h00 && $past(dma_cfg) == 5'h00 |-> !dma_req)
    else $error("dma request with all sources masked");
endmodule
bind multi_channel_pwm_timer pwm_timer_monitor #(
  .NCH(NCH)
) u_pwm_timer_monitor (
  .core_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr,
  .ch_out, .ch_oe, .ch_out_n, .ch_oe_n, .dbg_halt,
  .trig_out, .dac_trig, .dma_req, .irq
);

// *** pwm_timer_partner.sv ***
// far-side model: encoder, hall sensors and capture source
`timescale 1ns/1ps
module pwm_timer_partner (
  input  wire logic       core_clk,
  input  wire logic       step,
  input  wire logic       dir,
  input  wire logic       cap,
  output logic      [3:0] ch_in
);
  logic [1:0] phase = 2'h0;
  always @(posedge core_clk)
    if (step)
      phase <= dir ? phase + 2'h1 : phase - 2'h1;
  // hall lines follow rotor
  // push-pull sensor pins, so never left floating
  assign ch_in = {cap, phase[1], phase[1], phase[1] ^ phase[0]};
endmodule

// *** pwm_timer_pkg.sv ***
// types shared by the pwm timer files
package pwm_timer_pkg;
  typedef enum logic [1:0] {
    CH_CAPTURE = 2'h0,
    CH_COMPARE = 2'h1,
    CH_PWM     = 2'h2,
    CH_ONEPULSE = 2'h3
  } chan_mode_e;
  typedef enum logic [2:0] {
    SL_NONE    = 3'h0,
    SL_RESET   = 3'h1,
    SL_GATED   = 3'h2,
    SL_START   = 3'h3,
    SL_EXTCLK  = 3'h4,
    SL_ENCODER = 3'h5
  } slave_mode_e;
  typedef enum logic [2:0] {
    CNT_IDLE = 3'b001,
    CNT_UP   = 3'b010,
    CNT_DOWN = 3'b100
  } cnt_state_e;
  typedef struct packed {
    logic       active_low;
    chan_mode_e mode;
  } chan_cfg_s;
  typedef struct packed {
    logic        hall;
    logic        dbg_off;
    logic        freeze;
    slave_mode_e slave;
    logic        onepulse;
    logic        center;
    logic        down;
    logic        en;
  } ctrl_s;
endpackage
